// file: shared/ctabs_defs.svh
`ifndef CTABS_DEFS_SVH
`define CTABS_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CTABS_NUM_BUF        3
`define CTABS_WIN_WORDS      4
`define CTABS_MEM_WORDS      12

// ----------------------------------------------------------------
// register byte offsets on the wishbone slave
// ----------------------------------------------------------------
`define CTABS_OFS_EMPTY      8'h00
`define CTABS_OFS_ABORT_REQ  8'h04
`define CTABS_OFS_ABORT_ACK  8'h08
`define CTABS_OFS_BUF_SEL    8'h0C
`define CTABS_OFS_INIT       8'h10
`define CTABS_OFS_IRQ_STAT   8'h14
`define CTABS_OFS_IRQ_CLR    8'h18
`define CTABS_OFS_IRQ_EN     8'h1C
`define CTABS_WIN_PAGE       4'h4

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTABS_INIT_REQ_BIT   0
`define CTABS_INIT_ACK_BIT   1
`define CTABS_IRQ_BLOCK_BIT  3
`define CTABS_EMPTY_RST      3'h7
`define CTABS_ABORT_RST      3'h0
`define CTABS_ACK_RST        3'h0
`define CTABS_SEL_RST        3'h0
`define CTABS_IRQ_RST        4'h0

`endif

// file: shared/ctabs_pkg.sv
`include "ctabs_defs.svh"

package ctabs_pkg;

  // ----------------------------------------------------------------
  // state of the control module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         initReq;
    logic                         initAck;
    logic [`CTABS_NUM_BUF-1:0]    empty;
    logic [`CTABS_NUM_BUF-1:0]    abortReq;
    logic [`CTABS_NUM_BUF-1:0]    abortAck;
    logic [`CTABS_NUM_BUF-1:0]    bufSel;
    logic [3:0]                   irqStat;
    logic [3:0]                   irqEn;
    logic                         irq;
    logic                         ack;
    logic [31:0]                  datOut;
    logic [31:0]                  engData;
    logic [`CTABS_NUM_BUF-1:0]    pending;
  } ctabs_ctrl_t;

  // ----------------------------------------------------------------
  // state of the buffer store
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`CTABS_MEM_WORDS-1:0][31:0] mem;
  } ctabs_store_t;

endpackage

// file: shared/ctabs_win_if.sv
`timescale 1ns/1ps

// path between the control logic and the message buffer store
interface ctabs_win_if;
  logic [1:0]  winIdx;    // buffer mapped into the window
  logic [1:0]  winWord;   // word inside the window
  logic        winWrite;  // apply a write this cycle
  logic [3:0]  winSel;    // byte lanes of the write
  logic [31:0] winWrData; // write data
  logic [31:0] winRdData; // read data of the window word
  logic [1:0]  engIdx;    // transmitter buffer fetch
  logic [1:0]  engWord;   // transmitter word fetch
  logic [31:0] engRdData; // transmitter fetch data

  modport ctrl (
    output winIdx, winWord, winWrite, winSel, winWrData, engIdx, engWord,
    input  winRdData, engRdData
  );
  modport store (
    input  winIdx, winWord, winWrite, winSel, winWrData, engIdx, engWord,
    output winRdData, engRdData
  );
endinterface

// file: hdl/ctabs_buf_store.sv
`timescale 1ns/1ps

// three transmit message buffers, one window port and one fetch port
module ctabs_buf_store (
  input  wire logic     clock,   // module clock
  input  wire logic     sys_rst, // async reset, active high
  ctabs_win_if.store    win      // window and fetch path
);

  ctabs_pkg::ctabs_store_t stReg;
  ctabs_pkg::ctabs_store_t stNext;
  logic [3:0]              winAddr;
  logic [3:0]              engAddr;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  // index 3 of a buffer is never driven by the control side
  assign winAddr = {win.winIdx, win.winWord};
  assign engAddr = {win.engIdx, win.engWord};
  assign win.winRdData = stReg.mem[winAddr];
  assign win.engRdData = stReg.mem[engAddr];

  // ----------------------------------------------------------------
  // byte-lane writes
  // ----------------------------------------------------------------
  always_comb begin
    stNext = stReg;
    if (win.winWrite) begin
      for (int b = 0; b < 4; b++) begin
        if (win.winSel[b]) begin
          stNext.mem[winAddr][b*8 +: 8] = win.winWrData[b*8 +: 8];
        end
      end
    end
  end

  // message contents have no meaning after reset, zero keeps reads defined
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

endmodule

// file: hdl/ctabs_tx_ctrl.sv
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ctabs_defs.svh"

module ctabs_tx_ctrl (
  input  wire logic        clock,      // module clock, 100 MHz
  input  wire logic        sys_rst,    // async reset, active high
  input  wire logic [7:0]  wb_adr_i,   // wishbone byte address
  input  wire logic [31:0] wb_dat_i,   // wishbone write data
  output logic      [31:0] wb_dat_o,   // wishbone read data
  input  wire logic        wb_we_i,    // wishbone write enable
  input  wire logic [3:0]  wb_sel_i,   // wishbone byte lanes
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  output logic             wb_ack_o,   // wishbone acknowledge
  output logic             irq,        // level interrupt
  input  wire logic [2:0]  txActive,   // frame of buffer on the bus
  input  wire logic [2:0]  txSent,     // pulse, frame sent ok
  input  wire logic [2:0]  txFailed,   // pulse, lost arbitration or error
  output logic      [2:0]  txPending,  // buffers scheduled for sending
  input  wire logic [1:0]  engRdBuf,   // transmitter fetch buffer
  input  wire logic [1:0]  engRdWord,  // transmitter fetch word
  output logic      [31:0] engRdData   // fetch data, one cycle later
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctabs_pkg::ctabs_ctrl_t cReg;
  ctabs_pkg::ctabs_ctrl_t cNext;

  ctabs_win_if win ();

  ctabs_buf_store u_store (
    .clock   (clock),
    .sys_rst (sys_rst),
    .win     (win.store)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        busReq;
  logic        busStart;
  logic        busTake;
  logic        wrTake;
  logic [7:0]  regAdr;
  logic        inWin;
  logic [2:0]  wrBits;

  // a request starts one cycle before ack; the write lands on the ack edge
  assign busReq   = wb_cyc_i & wb_stb_i;
  assign busStart = busReq & ~cReg.ack;
  assign busTake  = busReq & cReg.ack;
  assign wrTake   = busTake & wb_we_i & wb_sel_i[0];
  assign regAdr   = {wb_adr_i[7:2], 2'b00};
  assign inWin    = (wb_adr_i[7:4] == `CTABS_WIN_PAGE);
  assign wrBits   = wb_dat_i[2:0];

  // ----------------------------------------------------------------
  // mode
  // ----------------------------------------------------------------
  logic inInit;
  logic writable;

  // init is entered only when request and acknowledge are both set
  assign inInit   = cReg.initReq & cReg.initAck;
  assign writable = ~cReg.initReq & ~cReg.initAck;

  // ----------------------------------------------------------------
  // window selection
  // ----------------------------------------------------------------
  logic [2:0] selLow;
  logic [1:0] selIdx;
  logic       winOpen;

  // isolate the lowest set bit; higher bits take no part
  assign selLow = cReg.bufSel & (~cReg.bufSel + 3'h1);

  always_comb begin
    selIdx = 2'h0;
    if (selLow[1]) begin
      selIdx = 2'h1;
    end else if (selLow[2]) begin
      selIdx = 2'h2;
    end
  end

  // window open only for a selected buffer that is not scheduled
  assign winOpen = (|selLow) & cReg.empty[selIdx];

  assign win.winIdx    = selIdx;
  assign win.winWord   = wb_adr_i[3:2];
  assign win.winWrite  = busTake & wb_we_i & inWin & winOpen;
  assign win.winSel    = wb_sel_i;
  assign win.winWrData = wb_dat_i;
  assign win.engIdx    = engRdBuf;
  assign win.engWord   = engRdWord;

  // ----------------------------------------------------------------
  // abort grant
  // ----------------------------------------------------------------
  logic [2:0] grant;
  logic [2:0] emptySet;

  // a buffer whose frame completed this cycle was sent, not aborted
  assign grant = cReg.abortReq & ~cReg.empty & ~txSent
                 & (~txActive | txFailed);

  // a successful send and a granted abort both free the buffer
  assign emptySet = txSent | grant;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [2:0] schedWr;
  logic [2:0] abortWr;
  logic [3:0] irqEvt;
  logic [3:0] irqClr;
  logic       winTouch;

  always_comb begin
    cNext = cReg;

    // register writes decoded per target
    schedWr = 3'h0;
    abortWr = 3'h0;
    irqClr  = 4'h0;
    if (wrTake && writable && regAdr == `CTABS_OFS_EMPTY) begin
      // a one schedules the buffer, a zero leaves it alone
      schedWr = wrBits & cReg.empty;
    end
    if (wrTake && writable && regAdr == `CTABS_OFS_ABORT_REQ) begin
      // only a scheduled buffer may carry a request
      abortWr = wrBits & ~cReg.empty;
    end
    if (wrTake && regAdr == `CTABS_OFS_IRQ_CLR) begin
      irqClr = wb_dat_i[3:0];
    end
    if (wrTake && regAdr == `CTABS_OFS_IRQ_EN) begin
      cNext.irqEn = wb_dat_i[3:0];
    end
    if (wrTake && regAdr == `CTABS_OFS_INIT) begin
      cNext.initReq = wb_dat_i[`CTABS_INIT_REQ_BIT];
    end
    if (wrTake && writable && regAdr == `CTABS_OFS_BUF_SEL) begin
      cNext.bufSel = wrBits;
    end

    // the controller acknowledges an init request one cycle later
    cNext.initAck = cReg.initReq;

    // set wins over a clear arriving in the same cycle
    cNext.empty = (cReg.empty & ~schedWr) | emptySet;

    // cleared whenever the empty flag is set; writing a zero cannot clear it
    cNext.abortReq = (cReg.abortReq | abortWr) & ~cNext.empty;

    // flag survives until software schedules the buffer again or init flushes it
    cNext.abortAck = (cReg.abortAck & ~schedWr) | grant;

    // init holds the transmit registers at their reset values
    if (inInit) begin
      cNext.empty    = `CTABS_EMPTY_RST;
      cNext.abortReq = `CTABS_ABORT_RST;
      cNext.abortAck = `CTABS_ACK_RST;
      cNext.bufSel   = `CTABS_SEL_RST;
    end

    cNext.pending = ~cNext.empty;

    // interrupt events: buffer freed, and a refused window access
    winTouch = busTake & inWin & ~winOpen;
    irqEvt   = {winTouch, emptySet};
    cNext.irqStat = (cReg.irqStat & ~irqClr) | irqEvt;
    cNext.irq     = |(cNext.irqStat & cNext.irqEn);

    // single-cycle answer: ack one cycle after the request appears
    cNext.ack    = busStart;
    cNext.datOut = 32'h0;
    if (busStart && !wb_we_i) begin
      if (inWin) begin
        // blocked window reads return zero
        cNext.datOut = winOpen ? win.winRdData : 32'h0;
      end else begin
        case (regAdr)
          `CTABS_OFS_EMPTY: begin
            cNext.datOut = {29'h0, cReg.empty};
          end
          `CTABS_OFS_ABORT_REQ: begin
            cNext.datOut = {29'h0, cReg.abortReq};
          end
          `CTABS_OFS_ABORT_ACK: begin
            cNext.datOut = {29'h0, cReg.abortAck};
          end
          `CTABS_OFS_BUF_SEL: begin
            cNext.datOut = {29'h0, selLow};
          end
          `CTABS_OFS_INIT: begin
            cNext.datOut = {30'h0, cReg.initAck, cReg.initReq};
          end
          `CTABS_OFS_IRQ_STAT: begin
            cNext.datOut = {28'h0, cReg.irqStat};
          end
          `CTABS_OFS_IRQ_EN: begin
            cNext.datOut = {28'h0, cReg.irqEn};
          end
          default: begin
            cNext.datOut = 32'h0;
          end
        endcase
      end
    end

    // transmitter fetch is registered so the output comes from a flop
    cNext.engData = win.engRdData;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cReg          <= '0;
      cReg.empty    <= `CTABS_EMPTY_RST;
      cReg.abortReq <= `CTABS_ABORT_RST;
      cReg.abortAck <= `CTABS_ACK_RST;
      cReg.bufSel   <= `CTABS_SEL_RST;
      cReg.irqStat  <= `CTABS_IRQ_RST;
      cReg.irqEn    <= `CTABS_IRQ_RST;
    end else begin
      cReg <= cNext;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o  = cReg.datOut;
  assign wb_ack_o  = cReg.ack;
  assign irq       = cReg.irq;
  assign txPending = cReg.pending;
  assign engRdData = cReg.engData;

endmodule

// file: test/ctabs_tx_partner.sv
`timescale 1ns/1ps

// ----------------------------------------
// transmitter and bus side model
// ----------------------------------------
// mode 0 sends, 1 stalls on the bus, 2 loses arbitration, 3 stays idle
module ctabs_tx_partner (
  input  wire logic       clock,     // module clock
  input  wire logic       sys_rst,   // async reset
  input  wire logic [1:0] mode,      // behaviour set by the bench
  input  wire logic [2:0] txPending, // scheduled buffers
  output logic      [2:0] txActive,  // frame on the bus
  output logic      [2:0] txSent,    // sent pulse
  output logic      [2:0] txFailed,  // failed pulse
  output logic      [1:0] engRdBuf,  // fetch buffer
  output logic      [1:0] engRdWord  // fetch word
);
  logic [3:0] cnt; // cycles since the frame began, saturates

  // one frame at a time, lowest scheduled buffer first
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      txActive <= 3'h0;
      txSent <= 3'h0;
      txFailed <= 3'h0;
      engRdBuf <= 2'h0;
      engRdWord <= 2'h0;
      cnt <= 4'h0;
    end else begin
      txSent <= 3'h0;
      txFailed <= 3'h0;
      engRdWord <= cnt[1:0];
      engRdBuf <= txActive[2] ? 2'h2 : {1'b0, txActive[1]};
      if (cnt < 4'h8) begin
        cnt <= cnt + 4'h1;
      end
      if (txActive == 3'h0) begin
        cnt <= 4'h0;
        if (mode != 2'h3) begin
          txActive <= txPending & ~(txPending - 3'h1);
        end
      end else if ((txActive & txPending) == 3'h0) begin
        txActive <= 3'h0; // buffer withdrawn, so the frame is dropped
      end else if (cnt >= 4'h4 && mode == 2'h0) begin
        txSent <= txActive;
        txActive <= 3'h0;
      end else if (cnt >= 4'h4 && mode == 2'h2) begin
        txFailed <= txActive;
        txActive <= 3'h0;
      end
    end
  end
endmodule

// file: test/ctabs_tx_ctrl_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------
// port checks of the transmit control
// ----------------------------------------
module ctabs_tx_ctrl_assertions (
  input wire logic        clock,     // module clock
  input wire logic        sys_rst,   // async reset
  input wire logic [7:0]  wb_adr_i,  // address
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic        wb_we_i,   // write enable
  input wire logic [3:0]  wb_sel_i,  // byte lanes
  input wire logic        wb_cyc_i,  // cycle
  input wire logic        wb_stb_i,  // strobe
  input wire logic        wb_ack_o,  // acknowledge
  input wire logic        irq,       // interrupt
  input wire logic [2:0]  txActive,  // frame on bus
  input wire logic [2:0]  txSent,    // sent pulse
  input wire logic [2:0]  txFailed,  // failed pulse
  input wire logic [2:0]  txPending  // scheduled
);
  logic initShadow; // copy of the init request bit
  logic rdAck;      // read answered this cycle

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  assign rdAck = wb_ack_o && !wb_we_i;

  // init flushes the flags, so a pending fall is legal then
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      initShadow <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h04) begin
      initShadow <= wb_dat_i[0];
    end
  end

  property p_ackOnce;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackOnce: assert property (p_ackOnce)
    else $error("ack held longer than one cycle");
  property p_ackNext;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ackNext: assert property (p_ackNext)
    else $error("request not answered in the next cycle");
  property p_datIdle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_datIdle: assert property (p_datIdle)
    else $error("read data not zero outside ack");
  property p_selLowest;
    rdAck && wb_adr_i[7:2] == 6'h03 |-> $onehot0(wb_dat_o);
  endproperty
  a_selLowest: assert property (p_selLowest)
    else $error("selection read shows more than one bit");
  property p_ackOnlyEmpty;
    rdAck && wb_adr_i[7:2] == 6'h02 |-> (wb_dat_o[2:0] & $past(txPending)) == 3'h0;
  endproperty
  a_ackOnlyEmpty: assert property (p_ackOnlyEmpty)
    else $error("abort ack set on a scheduled buffer");
  property p_abortOnlyPending;
    rdAck && wb_adr_i[7:2] == 6'h01 |-> (wb_dat_o[2:0] & ~$past(txPending)) == 3'h0;
  endproperty
  a_abortOnlyPending: assert property (p_abortOnlyPending)
    else $error("abort request left on an empty buffer");
  property p_sentEmpties;
    (txSent & txPending) != 3'h0 |=> (txPending & $past(txSent)) == 3'h0;
  endproperty
  a_sentEmpties: assert property (p_sentEmpties)
    else $error("sent buffer still scheduled");
  property p_pendingByWrite;
    (txPending & ~$past(txPending)) != 3'h0 |-> $past(wb_ack_o && wb_we_i);
  endproperty
  a_pendingByWrite: assert property (p_pendingByWrite)
    else $error("buffer scheduled without a write");
  property p_grantGate;
    !initShadow |-> ($past(txPending & ~txSent & txActive & ~txFailed) & ~txPending) == 3'h0;
  endproperty
  a_grantGate: assert property (p_grantGate)
    else $error("abort granted during a live frame");
  property p_irqCause;
    $rose(irq) |-> ($past(txPending) & ~txPending) != 3'h0 || $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_irqCause: assert property (p_irqCause)
    else $error("interrupt rose without an event");

  c_abort: cover property (($past(txPending) & ~txPending & ~$past(txSent)) != 3'h0);
  c_sent: cover property ((txSent & txPending) != 3'h0);
  c_irq: cover property ($rose(irq));
endmodule

bind ctabs_tx_ctrl ctabs_tx_ctrl_assertions chk_u (
  .clock, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .irq, .txActive, .txSent, .txFailed, .txPending
);

// file: test/tb_top.sv
`timescale 1ns/1ps
`include "ctabs_defs.svh"

// ----------------------------------------
// register level bench
// ----------------------------------------
module tb_top;
  logic        clock;     // module clock
  logic        sysRst;    // reset
  logic [7:0]  wbAdr;     // address
  logic [31:0] wbDatW;    // write data
  logic [31:0] wbDatR;    // read data
  logic        wbWe;      // write enable
  logic        wbCyc;     // cycle
  logic        wbStb;     // strobe
  logic        wbAck;     // acknowledge
  logic        irq;       // interrupt
  logic [2:0]  txActive;  // frame on bus
  logic [2:0]  txSent;    // sent pulse
  logic [2:0]  txFailed;  // failed pulse
  logic [2:0]  txPending; // scheduled
  logic [1:0]  engRdBuf;  // fetch buffer
  logic [1:0]  engRdWord; // fetch word
  logic [31:0] engRdData; // fetch data
  logic [1:0]  mode;      // partner behaviour
  logic [31:0] rdData;    // last read value
  int          errTotal;  // mismatches
  int          nTests;    // comparisons
  int          tick;      // cycles run

  ctabs_tx_ctrl dut_u (.clock(clock), .sys_rst(sysRst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_we_i(wbWe), .wb_sel_i(4'hF), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_ack_o(wbAck), .irq(irq), .txActive(txActive), .txSent(txSent), .txFailed(txFailed),
    .txPending(txPending), .engRdBuf(engRdBuf), .engRdWord(engRdWord), .engRdData(engRdData));
  ctabs_tx_partner peer_u (.clock(clock), .sys_rst(sysRst), .mode(mode), .txPending(txPending),
    .txActive(txActive), .txSent(txSent), .txFailed(txFailed), .engRdBuf(engRdBuf),
    .engRdWord(engRdWord));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic completeRun();
    if (errTotal == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; the idle cycle after it keeps strobes apart
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wbAdr <= adr;
    wbDatW <= dat;
    wbWe <= we;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    @(posedge clock);
    while (wbAck !== 1'b1) @(posedge clock);
    rdData = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rdData, exp);
  endtask

  // watchdog against a hang
  always @(posedge clock) begin
    tick <= tick + 1;
    if (tick == 5000) begin
      errTotal++;
      completeRun();
    end
  end

  initial begin
    {sysRst, wbAdr, wbDatW, wbWe, wbCyc, wbStb, mode, errTotal, nTests, tick} = '1;
    {wbAdr, wbDatW, wbWe, wbCyc, wbStb, errTotal, nTests, tick} = '0;
    repeat (4) @(posedge clock);
    sysRst <= 1'b0;
    @(posedge clock);
    rd(`CTABS_OFS_EMPTY, 32'h7);
    rd(`CTABS_OFS_ABORT_ACK, 32'h0);
    wr(`CTABS_OFS_BUF_SEL, 32'h6);
    rd(`CTABS_OFS_BUF_SEL, 32'h2);
    wr(8'h40, 32'hA5A50001);
    wr(`CTABS_OFS_BUF_SEL, 32'h1);
    rd(8'h40, 32'h0);
    wr(`CTABS_OFS_BUF_SEL, 32'h2);
    rd(8'h40, 32'hA5A50001);
    rd(8'h20, 32'h0);
    // no selection: access refused and flagged
    wr(`CTABS_OFS_BUF_SEL, 32'h0);
    wr(8'h40, 32'h1);
    rd(`CTABS_OFS_IRQ_STAT, 32'h8);
    wr(`CTABS_OFS_IRQ_EN, 32'hF);
    chk({31'h0, irq}, 32'h1);
    wr(`CTABS_OFS_IRQ_CLR, 32'h8);
    chk({31'h0, irq}, 32'h0);
    // a stalled frame blocks the window and the abort
    mode <= 2'h1;
    wr(`CTABS_OFS_BUF_SEL, 32'h1);
    wr(8'h40, 32'h5A);
    // idle fetch points at buffer 0 word 0; the fetch flop lags one more edge
    @(posedge clock);
    chk(engRdData, 32'h5A);
    wr(`CTABS_OFS_EMPTY, 32'h1);
    wr(`CTABS_OFS_EMPTY, 32'h0);
    rd(`CTABS_OFS_EMPTY, 32'h6);
    rd(8'h40, 32'h0);
    wr(`CTABS_OFS_ABORT_REQ, 32'h3);
    rd(`CTABS_OFS_ABORT_REQ, 32'h1);
    wr(`CTABS_OFS_ABORT_REQ, 32'h0);
    rd(`CTABS_OFS_ABORT_REQ, 32'h1);
    rd(`CTABS_OFS_EMPTY, 32'h6);
    mode <= 2'h2;
    repeat (10) @(posedge clock);
    rd(`CTABS_OFS_EMPTY, 32'h7);
    rd(`CTABS_OFS_ABORT_REQ, 32'h0);
    wr(`CTABS_OFS_ABORT_ACK, 32'h0);
    rd(`CTABS_OFS_ABORT_ACK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    mode <= 2'h3;
    wr(`CTABS_OFS_EMPTY, 32'h1);
    rd(`CTABS_OFS_ABORT_ACK, 32'h0);
    wr(`CTABS_OFS_ABORT_REQ, 32'h1);
    rd(`CTABS_OFS_ABORT_ACK, 32'h1);
    // init flushes a held request, the ack and the selection
    mode <= 2'h1;
    wr(`CTABS_OFS_EMPTY, 32'h2);
    wr(`CTABS_OFS_ABORT_REQ, 32'h2);
    rd(`CTABS_OFS_ABORT_REQ, 32'h2);
    wr(`CTABS_OFS_INIT, 32'h1);
    repeat (2) @(posedge clock);
    rd(`CTABS_OFS_ABORT_REQ, 32'h0);
    rd(`CTABS_OFS_ABORT_ACK, 32'h0);
    wr(`CTABS_OFS_BUF_SEL, 32'h4);
    rd(`CTABS_OFS_BUF_SEL, 32'h0);
    wr(`CTABS_OFS_EMPTY, 32'h4);
    rd(`CTABS_OFS_EMPTY, 32'h7);
    wr(`CTABS_OFS_INIT, 32'h0);
    repeat (2) @(posedge clock);
    // the selection write made during init must not have landed
    rd(`CTABS_OFS_BUF_SEL, 32'h0);
    mode <= 2'h0;
    wr(`CTABS_OFS_EMPTY, 32'h4);
    repeat (12) @(posedge clock);
    rd(`CTABS_OFS_EMPTY, 32'h7);
    rd(`CTABS_OFS_ABORT_ACK, 32'h0);
    completeRun();
  end
endmodule
